// ---- rtl/hbe_pkg.sv ----
// Package for the host bus emulation master: constants, command and state types
//
// Behaviour
// - The address and data share one 8-bit two-way bus, low address byte first and then data.
// - The upper eight address bits of every access are driven on their own output lines.
// - The active-low select line goes low after the address phase and stays low to the end of every read or write access.
// - A positive address latch pulse is given while the low address byte is on the bus.
// - The read strobe is driven low to ask the peripheral for read data.
// - Write data is on the bus before the write strobe falls and stays until after it rises.
// - While the wait input is low the access is stretched, and it ends only once it is high.
// - The clock that the bus logic runs from is driven out on the interface clock pin.
// - Both auxiliary pins can be driven high or low and read back through commands.
// - Commands exist that stall command processing until auxiliary pin 1 is high, or low.
// - After a wait on the interrupt level ends, the next queued bus read runs and its byte is returned.
// - Auxiliary pin 1 is kept as an input whenever a wait-on-level command is used.
// - Both channels form one bus master, so there is a single command stream and one bus.
// - A separate 4096-command transmit buffer and 4 kbyte receive buffer sit between the host link and the bus logic.
package hbe_pkg;

  localparam int HBE_BYTE_W    = 8;
  localparam int HBE_AUX_W     = 2;
  localparam int HBE_AUX_IRQ   = 1;
  localparam int HBE_BUF_BYTES = 4096;
  localparam int HBE_PTR_W     = 12;

  typedef enum logic [2:0] {
    HBE_OP_WRITE   = 3'h0,
    HBE_OP_READ    = 3'h1,
    HBE_OP_SET_AUX = 3'h2,
    HBE_OP_GET_AUX = 3'h3,
    HBE_OP_WAIT_HI = 3'h4,
    HBE_OP_WAIT_LO = 3'h5
  } hbe_op_type;

  // For HBE_OP_SET_AUX: data holds pin levels, addrLow holds drive enables
  typedef struct packed {
    hbe_op_type            op;
    logic [HBE_BYTE_W-1:0] addrHigh;
    logic [HBE_BYTE_W-1:0] addrLow;
    logic [HBE_BYTE_W-1:0] data;
  } hbe_cmd_type;

  localparam int HBE_CMD_W = $bits(hbe_cmd_type);

  typedef enum logic [2:0] {
    HBE_ST_IDLE    = 3'h0,
    HBE_ST_LATCH   = 3'h1,
    HBE_ST_HOLD    = 3'h2,
    HBE_ST_SETUP   = 3'h3,
    HBE_ST_STROBE  = 3'h4,
    HBE_ST_RELEASE = 3'h5,
    HBE_ST_LEVEL   = 3'h6
  } hbe_state_type;

endpackage : hbe_pkg

// ---- rtl/hbe_bus_master.sv ----
// Host bus emulation master with its transmit and receive buffers
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Buffer of WIDTH-bit entries (bytes or commands)
// ----------------------------------------------------------------
module hbe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4096,
  parameter int PTR_W = 12
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0]   count;
  logic [PTR_W-1:0] next_wrPtr;
  logic [PTR_W-1:0] next_rdPtr;
  logic [PTR_W:0]   next_count;
  logic             doWrite;
  logic             doRead;

  assign inReady  = (count != (PTR_W+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_comb
  begin
    next_wrPtr = doWrite ? wrPtr + PTR_W'(1) : wrPtr;
    next_rdPtr = doRead ? rdPtr + PTR_W'(1) : rdPtr;
    next_count = count + (PTR_W+1)'(doWrite) - (PTR_W+1)'(doRead);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk)
  begin
    if (doWrite)
    begin
      mem[wrPtr] <= inData;
    end
  end
endmodule : hbe_fifo

// ----------------------------------------------------------------
// Bus master
// ----------------------------------------------------------------
module hbe_bus_master (
  input  wire logic                             clk,
  input  wire logic                             rstn,
  input  wire hbe_pkg::hbe_cmd_type             cmdData,
  input  wire logic                             cmdValid,
  output logic                                  cmdReady,
  output logic      [hbe_pkg::HBE_BYTE_W-1:0]   respData,
  output logic                                  respValid,
  input  wire logic                             respReady,
  input  wire logic [hbe_pkg::HBE_BYTE_W-1:0]   addrDataIn,
  output logic      [hbe_pkg::HBE_BYTE_W-1:0]   addrDataOut,
  output logic                                  addrDataOe,
  output logic      [hbe_pkg::HBE_BYTE_W-1:0]   highAddressOut,
  output logic                                  addressLatchStrobe,
  output logic                                  selectN,
  output logic                                  readStrobeN,
  output logic                                  writeStrobeN,
  input  wire logic                             waitReadyIn,
  output logic                                  interfaceClockOut,
  input  wire logic [hbe_pkg::HBE_AUX_W-1:0]    auxIoIn,
  output logic      [hbe_pkg::HBE_AUX_W-1:0]    auxIoOut,
  output logic      [hbe_pkg::HBE_AUX_W-1:0]    auxIoOe
);
  import hbe_pkg::*;

  hbe_state_type         state;
  hbe_state_type         next_state;
  hbe_cmd_type           cmd;
  hbe_cmd_type           next_cmd;
  hbe_cmd_type           txData;
  logic                  txValid;
  logic                  txPop;
  logic [HBE_BYTE_W-1:0] rxData;
  logic                  rxReady;
  logic                  rxPush;
  logic [HBE_BYTE_W-1:0] next_addrDataOut;
  logic                  next_addrDataOe;
  logic [HBE_BYTE_W-1:0] next_highAddressOut;
  logic                  next_addressLatchStrobe;
  logic                  next_selectN;
  logic                  next_readStrobeN;
  logic                  next_writeStrobeN;
  logic [HBE_AUX_W-1:0]  next_auxIoOut;
  logic [HBE_AUX_W-1:0]  next_auxIoOe;

  // ----------------------------------------------------------------
  // Buffers between host link and bus
  // ----------------------------------------------------------------
  hbe_fifo #(.WIDTH(HBE_CMD_W), .DEPTH(HBE_BUF_BYTES), .PTR_W(HBE_PTR_W)) txBuf (
    .clk      (clk),
    .rstn     (rstn),
    .inData   (cmdData),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .outData  (txData),
    .outValid (txValid),
    .outReady (txPop)
  );

  hbe_fifo #(.WIDTH(HBE_BYTE_W), .DEPTH(HBE_BUF_BYTES), .PTR_W(HBE_PTR_W)) rxBuf (
    .clk      (clk),
    .rstn     (rstn),
    .inData   (rxData),
    .inValid  (rxPush),
    .inReady  (rxReady),
    .outData  (respData),
    .outValid (respValid),
    .outReady (respReady)
  );

  assign interfaceClockOut = clk;

  // ----------------------------------------------------------------
  // Access sequencer, one command stream for the whole bus
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state              = state;
    next_cmd                = cmd;
    next_addrDataOut        = addrDataOut;
    next_addrDataOe         = addrDataOe;
    next_highAddressOut     = highAddressOut;
    next_addressLatchStrobe = 1'b0;
    next_selectN            = selectN;
    next_readStrobeN        = readStrobeN;
    next_writeStrobeN       = writeStrobeN;
    next_auxIoOut           = auxIoOut;
    next_auxIoOe            = auxIoOe;
    txPop                   = 1'b0;
    rxPush                  = 1'b0;
    rxData                  = '0;
    case (state)
      HBE_ST_IDLE:
      begin
        // Commands that answer wait for room so no byte is dropped
        if (txValid && (rxReady || (txData.op != HBE_OP_READ && txData.op != HBE_OP_GET_AUX)))
        begin
          txPop    = 1'b1;
          next_cmd = txData;
          case (txData.op)
            HBE_OP_WRITE, HBE_OP_READ:
            begin
              next_highAddressOut     = txData.addrHigh;
              next_addrDataOut        = txData.addrLow;
              next_addrDataOe         = 1'b1;
              next_addressLatchStrobe = 1'b1;
              next_state              = HBE_ST_LATCH;
            end
            HBE_OP_SET_AUX:
            begin
              next_auxIoOut = txData.data[HBE_AUX_W-1:0];
              next_auxIoOe  = txData.addrLow[HBE_AUX_W-1:0];
            end
            HBE_OP_GET_AUX:
            begin
              rxPush = 1'b1;
              rxData = {{(HBE_BYTE_W-HBE_AUX_W){1'b0}}, auxIoIn};
            end
            HBE_OP_WAIT_HI, HBE_OP_WAIT_LO:
            begin
              next_auxIoOe[HBE_AUX_IRQ] = 1'b0;
              next_state                = HBE_ST_LEVEL;
            end
            default:
            begin
              next_state = HBE_ST_IDLE;
            end
          endcase
        end
      end
      HBE_ST_LATCH:
      begin
        // Address still on the bus after the latch pulse falls
        next_state = HBE_ST_HOLD;
      end
      HBE_ST_HOLD:
      begin
        next_selectN = 1'b0;
        if (cmd.op == HBE_OP_WRITE)
        begin
          next_addrDataOut = cmd.data;
          next_addrDataOe  = 1'b1;
        end
        else
        begin
          next_addrDataOe = 1'b0;
        end
        next_state = HBE_ST_SETUP;
      end
      HBE_ST_SETUP:
      begin
        if (cmd.op == HBE_OP_WRITE)
        begin
          next_writeStrobeN = 1'b0;
        end
        else
        begin
          next_readStrobeN = 1'b0;
        end
        next_state = HBE_ST_STROBE;
      end
      HBE_ST_STROBE:
      begin
        if (waitReadyIn)
        begin
          next_readStrobeN  = 1'b1;
          next_writeStrobeN = 1'b1;
          if (cmd.op == HBE_OP_READ)
          begin
            rxPush = 1'b1;
            rxData = addrDataIn;
          end
          next_state = HBE_ST_RELEASE;
        end
      end
      HBE_ST_RELEASE:
      begin
        // Write data held one cycle past the strobe's rise
        next_selectN    = 1'b1;
        next_addrDataOe = 1'b0;
        next_state      = HBE_ST_IDLE;
      end
      HBE_ST_LEVEL:
      begin
        next_auxIoOe[HBE_AUX_IRQ] = 1'b0;
        if (auxIoIn[HBE_AUX_IRQ] == (cmd.op == HBE_OP_WAIT_HI))
        begin
          next_state = HBE_ST_IDLE;
        end
      end
      default:
      begin
        next_state = HBE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state              <= HBE_ST_IDLE;
      cmd                <= '0;
      addrDataOut        <= '0;
      addrDataOe         <= 1'b0;
      highAddressOut     <= '0;
      addressLatchStrobe <= 1'b0;
      selectN            <= 1'b1;
      readStrobeN        <= 1'b1;
      writeStrobeN       <= 1'b1;
      auxIoOut           <= '0;
      auxIoOe            <= '0;
    end
    else
    begin
      state              <= next_state;
      cmd                <= next_cmd;
      addrDataOut        <= next_addrDataOut;
      addrDataOe         <= next_addrDataOe;
      highAddressOut     <= next_highAddressOut;
      addressLatchStrobe <= next_addressLatchStrobe;
      selectN            <= next_selectN;
      readStrobeN        <= next_readStrobeN;
      writeStrobeN       <= next_writeStrobeN;
      auxIoOut           <= next_auxIoOut;
      auxIoOe            <= next_auxIoOe;
    end
  end
endmodule : hbe_bus_master

`default_nettype wire

// ---- dv/hbe_bus_master_sva.sv ----
// Checker for the bus side of the host bus emulation master
`timescale 1ns/10ps
`default_nettype none
module hbe_bus_master_sva (
  input wire logic                           clk,
  input wire logic                           rstn,
  input wire logic [hbe_pkg::HBE_BYTE_W-1:0] addrDataOut,
  input wire logic                           addrDataOe,
  input wire logic                           addressLatchStrobe,
  input wire logic                           selectN,
  input wire logic                           readStrobeN,
  input wire logic                           writeStrobeN,
  input wire logic                           waitReadyIn,
  input wire logic                           interfaceClockOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic strb;
  assign strb = !readStrobeN || !writeStrobeN;
  sequence s_addr;
    addressLatchStrobe ##1 (!addressLatchStrobe && selectN);
  endsequence
  property p_order;
    $rose(addressLatchStrobe) |-> s_addr ##1 $fell(selectN);
  endproperty
  property p_ale_oe;
    addressLatchStrobe |-> addrDataOe;
  endproperty
  property p_strobe;
    $fell(selectN) |=> ($fell(readStrobeN) || $fell(writeStrobeN));
  endproperty
  property p_sel;
    strb |-> !selectN;
  endproperty
  property p_hold;
    $fell(selectN) |-> !selectN [*3];
  endproperty
  property p_wait;
    (strb && !waitReadyIn) |=> strb;
  endproperty
  property p_end;
    (strb && waitReadyIn) |=> !strb;
  endproperty
  property p_wsetup;
    $fell(writeStrobeN) |-> (addrDataOe && $stable(addrDataOut));
  endproperty
  property p_whold;
    $rose(writeStrobeN) |-> (addrDataOe && $stable(addrDataOut));
  endproperty
  property p_rbus;
    !readStrobeN |-> !addrDataOe;
  endproperty
  property p_clk;
    @(negedge clk) disable iff (!rstn) interfaceClockOut;
  endproperty
  a_order: assert property (p_order)
    else $error("select not two cycles after latch pulse");
  a_ale_oe: assert property (p_ale_oe)
    else $error("latch pulse without address on bus");
  a_strobe: assert property (p_strobe)
    else $error("strobe not one cycle after select");
  a_sel: assert property (p_sel)
    else $error("strobe outside select");
  a_hold: assert property (p_hold)
    else $error("select too short");
  a_wait: assert property (p_wait)
    else $error("access ended while wait low");
  a_end: assert property (p_end)
    else $error("access not ended after wait high");
  a_wsetup: assert property (p_wsetup)
    else $error("write data not set up");
  a_whold: assert property (p_whold)
    else $error("write data not held");
  a_rbus: assert property (p_rbus)
    else $error("bus driven during read strobe");
  a_clk: assert property (p_clk)
    else $error("interface clock differs");
endmodule : hbe_bus_master_sva
bind hbe_bus_master hbe_bus_master_sva i_hbe_bus_master_sva (.clk, .rstn, .addrDataOut,
  .addrDataOe, .addressLatchStrobe, .selectN, .readStrobeN, .writeStrobeN, .waitReadyIn,
  .interfaceClockOut);
`default_nettype wire

// ---- dv/hbe_periph_model.sv ----
// Peripheral on the multiplexed bus: byte store with a wait line
`timescale 1ns/10ps
`default_nettype none
module hbe_periph_model (
  input  wire logic       clk,
  input  wire logic [7:0] addrDataOut,
  input  wire logic       addrDataOe,
  input  wire logic       addressLatchStrobe,
  input  wire logic       selectN,
  input  wire logic       readStrobeN,
  input  wire logic       writeStrobeN,
  input  wire logic       slow,
  output logic            waitReadyIn,
  output logic      [7:0] busLevel
);
  logic [7:0] mem [256];
  logic [7:0] lat;
  logic [7:0] last = 8'h00;
  always @(negedge addressLatchStrobe) lat <= busLevel;
  always @(posedge writeStrobeN) if (!selectN) mem[lat] <= busLevel;
  always @(posedge clk) last <= busLevel;
  // Released bus shows a toggling pattern, never the old value
  always_comb
    if (addrDataOe) busLevel = addrDataOut;
    else if (!selectN && !readStrobeN) busLevel = mem[lat];
    else busLevel = ~last;
  initial
  begin
    waitReadyIn = 1'b1;
    forever
    begin
      @(posedge clk);
      #2;
      waitReadyIn = !slow || ($urandom % 3 == 0);
    end
  end
endmodule : hbe_periph_model
`default_nettype wire

// ---- dv/hbe_bus_master_tb.sv ----
// Self-checking bench for the host bus emulation master
`timescale 1ns/10ps
`default_nettype none
module hbe_bus_master_tb;
  import hbe_pkg::*;
  logic clk, rstn, cmdValid, cmdReady, respValid, respReady, waitReadyIn, slow;
  logic addrDataOe, addressLatchStrobe, selectN, readStrobeN, writeStrobeN, interfaceClockOut;
  hbe_cmd_type cmdData;
  logic [7:0] respData, addrDataIn, addrDataOut, highAddressOut, a8, hi[8], lo[8], d[8];
  logic [1:0] auxIoIn, auxIoOut, auxIoOe, auxDrv, lv, en;
  logic [15:0] addrQ[$];
  int fail_count, total_checks, cyc, aleCount, n;
  assign auxIoIn = (auxIoOe & auxIoOut) | (~auxIoOe & auxDrv);
  hbe_bus_master i_hbe_bus_master (.clk, .rstn, .cmdData, .cmdValid, .cmdReady, .respData,
    .respValid, .respReady, .addrDataIn, .addrDataOut, .addrDataOe, .highAddressOut,
    .addressLatchStrobe, .selectN, .readStrobeN, .writeStrobeN, .waitReadyIn,
    .interfaceClockOut, .auxIoIn, .auxIoOut, .auxIoOe);
  hbe_periph_model i_hbe_periph_model (.clk, .addrDataOut, .addrDataOe, .addressLatchStrobe,
    .selectN, .readStrobeN, .writeStrobeN, .slow, .waitReadyIn, .busLevel(addrDataIn));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] exp_aux(input logic [1:0] e, input logic [1:0] v,
                                         input logic [1:0] drv);
    return {6'h0, (e & v) | (~e & drv)};
  endfunction : exp_aux
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic send(input hbe_op_type op, input logic [7:0] h, l, v);
    @(posedge clk);
    #2;
    cmdData = '{op, h, l, v};
    cmdValid = 1'b1;
    if (op == HBE_OP_WRITE || op == HBE_OP_READ) addrQ.push_back({h, l});
    @(posedge clk);
    while (cmdReady !== 1'b1) @(posedge clk);
    #2 cmdValid = 1'b0;
  endtask : send
  task automatic expect_resp(input logic [7:0] exp);
    n = 0;
    do @(negedge clk); while (respValid !== 1'b1 && ++n < 300);
    check(respData, exp);
    @(posedge clk);
    #2;
  endtask : expect_resp
  // Address phase monitor and timeout, sampled where outputs are settled
  always @(negedge clk)
  begin
    if (addressLatchStrobe === 1'b1 && addrQ.size() > 0)
    begin
      aleCount++;
      a8 = addrQ[0][15:8];
      check(highAddressOut, a8);
      a8 = addrQ.pop_front();
      check(addrDataOut, a8);
    end
    if (++cyc > 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  initial
  begin
    rstn = 1'b0;
    cmdValid = 1'b0;
    cmdData = '0;
    respReady = 1'b1;
    slow = 1'b0;
    auxDrv = 2'h0;
    void'($urandom(32'h46b2));
    repeat (4) @(posedge clk);
    #2 rstn = 1'b1;
    check({2'h0, selectN, readStrobeN, writeStrobeN, addrDataOe, respValid, cmdReady}, 8'h39);
    for (int i = 0; i < 8; i++)
    begin
      hi[i] = (i == 7) ? 8'hff : 8'($urandom);
      lo[i] = (8'($urandom) & 8'hf8) | 8'(i);
      d[i] = (i == 7) ? 8'h00 : 8'($urandom);
      slow = i[0];
      send(HBE_OP_WRITE, hi[i], lo[i], d[i]);
    end
    for (int i = 0; i < 8; i++) send(HBE_OP_READ, hi[i], lo[i], 8'h00);
    for (int i = 0; i < 8; i++) expect_resp(d[i]);
    for (int k = 0; k < 4; k++)
    begin
      lv = 2'($urandom);
      en = 2'(k);
      auxDrv = 2'($urandom);
      send(HBE_OP_SET_AUX, 8'h00, {6'h0, en}, {6'h0, lv});
      repeat (2) @(negedge clk);
      check({4'h0, auxIoOe, auxIoOut & en}, {4'h0, en, lv & en});
      send(HBE_OP_GET_AUX, 8'h00, 8'h00, 8'h00);
      expect_resp(exp_aux(en, lv, auxDrv));
    end
    // Undefined op code: no access and no answer
    n = aleCount;
    send(hbe_op_type'(3'h7), 8'h5a, 8'h5a, 8'h5a);
    repeat (4) @(negedge clk);
    check({7'h0, respValid}, 8'h00);
    check(8'(aleCount - n), 8'h00);
    for (int w = 0; w < 2; w++)
    begin
      auxDrv = {1'(w), 1'b0};
      send(HBE_OP_SET_AUX, 8'h00, 8'h03, {6'h0, 1'(w), 1'(w)});
      send(w ? HBE_OP_WAIT_LO : HBE_OP_WAIT_HI, 8'h00, 8'h00, 8'h00);
      send(HBE_OP_READ, hi[w], lo[w], 8'h00);
      n = aleCount;
      repeat (30) @(posedge clk);
      check(8'(aleCount - n), 8'h00);
      check({7'h0, auxIoOe[1]}, 8'h00);
      #2 auxDrv[1] = ~1'(w);
      expect_resp(d[w]);
    end
    wrap_up();
  end
endmodule : hbe_bus_master_tb
`default_nettype wire
